/* speed_standby_pkg.sv */
// constants and types shared by the decoder speed and standby control
// assumes a single 125 MHz system clock drives every file of the block
package speed_standby_pkg;
   // system clock rate in MHz
   localparam int CLK_MHZ = 125;
   // fixed auxiliary clock and the two host clock rates, in MHz
   localparam int AUX_CLK_MHZ = 16;
   localparam int HOST_LO_MHZ = 4;
   localparam int HOST_HI_MHZ = 12;
   // half periods in system cycles, rounded down, never below one
   localparam int AUX_HALF_I = (CLK_MHZ / (2 * AUX_CLK_MHZ) < 1) ? 1 :
      CLK_MHZ / (2 * AUX_CLK_MHZ);
   localparam int HOST_LO_HALF_I = CLK_MHZ / (2 * HOST_LO_MHZ);
   localparam int HOST_HI_HALF_I = CLK_MHZ / (2 * HOST_HI_MHZ);
   localparam logic [7:0] AUX_HALF = AUX_HALF_I[7:0];
   localparam logic [7:0] HOST_LO_HALF = HOST_LO_HALF_I[7:0];
   localparam logic [7:0] HOST_HI_HALF = HOST_HI_HALF_I[7:0];
   // field positions in decoder registers b and e
   localparam int SPEED_BIT = 3;
   localparam int STBY_LSB = 0;
   localparam int LTD_BIT = 0;
   // standby field codes in register b
   localparam logic [1:0] STBY_CODE_STOP = 2'h1;
   localparam logic [1:0] STBY_CODE_PAUSE = 2'h2;
   // overspeed factor values
   localparam logic [2:0] FACTOR_1X = 3'h1;
   localparam logic [2:0] FACTOR_2X = 3'h2;
   localparam logic [2:0] FACTOR_4X = 3'h4;
   // slowest tracked disc speed is nominal divided by this
   localparam int LOCK_SLOW_DIV = 4;
   // number of pins that enter through synchronisers
   localparam int PIN_COUNT = 6;
   // standby states
   typedef enum logic [1:0] {stby_run, stby_stop, stby_pause} standby_t;
endpackage : speed_standby_pkg

/* pin_sync.sv */
// two flip-flop synchroniser for one pin input
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/10ps
module pin_sync
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // reset level and pin
   input wire logic rst_level,
   input wire logic pin,
   // synchronised level
   output logic level
);
   logic meta; // first stage, read only by the second

   // two stages; reset value is loaded by a clocked process
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         meta <= rst_level;
         level <= rst_level;
      end
      else
      begin
         meta <= pin;
         level <= meta;
      end
   end
endmodule : pin_sync

/* clock_divider.sv */
// square wave generator dividing clk_sys by twice a half period
// assumes half_count is at least one and steady while running
`timescale 1ns/10ps
module clock_divider
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // half period in system cycles
   input wire logic [7:0] half_count,
   // divided clock, from a flip-flop
   output logic clk_out
);
   logic [7:0] count; // cycles spent in the current half
   wire last = (count + 8'h01 >= half_count); // half period ends

   // count and toggle
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         count <= 8'h00;
         clk_out <= 1'b0;
      end
      else if (last)
      begin
         count <= 8'h00;
         clk_out <= ~clk_out;
      end
      else
         count <= count + 8'h01;
   end
endmodule : clock_divider

/* speed_standby_ctrl.sv */
// decoder speed, lock-to-disc and standby control with pin gating
// assumes register b and e images and core signals come from clk_sys logic
`timescale 1ns/10ps

// What this block does
// - offers single, double and quad overspeed
// - register b/e top bits pick speed
// - lock-to-disc bypasses fifo, audio follows disc
// - disc tracked only between 25 and 100%
// - register e enables lock-to-disc
// - two standby modes, core keeps running
// - stop mode switches audio and motor i/o off
// - hot pause mutes audio, motor/subcode run
// - audio pins tri-state in any standby
// - host interface pins unaffected by standby
// - crystal and clock outputs keep running
// - versatile pins and correction flag unaffected
// - motor outputs hi-z in stop, reset
// - host clock output selectable 4/12 MHz
// - active-low power-on reset pin
module speed_standby_ctrl
#(
   // nominal cycles between disc rotation ticks at full speed
   parameter int NOMINAL_INTERVAL = 1000
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // power-on reset pin, active low
   input wire logic reset_n,
   // decoder register images and configuration
   input wire logic [3:0] reg_b,
   input wire logic [3:0] reg_e,
   input wire logic voltage_mode,
   input wire logic host_clk_12m_sel,
   input wire logic motor_pdm_mode,
   // pins from outside
   input wire logic crystal_in,
   input wire logic disc_tick,
   input wire logic versatile_pin_first,
   input wire logic versatile_pin_second,
   input wire logic sda_in,
   // core audio sources, crystal rate and disc rate
   input wire logic sclk_xtal,
   input wire logic wclk_xtal,
   input wire logic sclk_disc,
   input wire logic wclk_disc,
   input wire logic audio_data,
   input wire logic c2_error,
   input wire logic biphase_data,
   // core motor, host and flag sources
   input wire logic [1:0] motor_pwm,
   input wire logic [1:0] motor_pdm,
   input wire logic sda_drive_low,
   input wire logic correction_flag,
   input wire logic [2:0] versatile_drive,
   // mode status
   output logic [2:0] overspeed_factor,
   output logic speed_reserved,
   output logic fifo_bypass,
   output logic lock_in_range,
   output logic core_active,
   output logic subcode_enable,
   output logic device_in_reset,
   // audio pins with active-low enables
   output logic audio_sclk_out,
   output logic audio_wclk_out,
   output logic audio_data_out,
   output logic c2_error_flag_out,
   output logic biphase_mark_out,
   output logic audio_oe_n,
   // motor pins with active-low enable
   output logic motor_drive_out_a,
   output logic motor_drive_out_b,
   output logic motor_oe_n,
   // clock and crystal outputs
   output logic crystal_out,
   output logic fixed_aux_clock_out,
   output logic selectable_host_clock_out,
   // host data line, open drain
   output logic sda_out,
   output logic sda_oe_n,
   // versatile pins, and correction flag open drain
   output logic [1:0] versatile_in_sync,
   output logic [2:0] versatile_out,
   output logic correction_flag_out,
   output logic correction_flag_oe_n
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   ////////////////////////////////////////////////////////////////////
   wire [speed_standby_pkg::PIN_COUNT-1:0] pins = {sda_in,
      versatile_pin_second, versatile_pin_first, disc_tick,
      crystal_in, reset_n}; // raw pin vector
   wire [speed_standby_pkg::PIN_COUNT-1:0] rst_levels = 6'h21; // idle
   logic [speed_standby_pkg::PIN_COUNT-1:0] synced; // second stages

   // one synchroniser per pin
   genvar gi;
   generate
      for (gi = 0; gi < speed_standby_pkg::PIN_COUNT; gi++)
      begin : g_sync
         pin_sync u_sync
         (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .rst_level(rst_levels[gi]),
            .pin(pins[gi]),
            .level(synced[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // reset, speed and mode decode
   ////////////////////////////////////////////////////////////////////
   logic dev_rst; // combined device reset
   wire next_dev_rst = sys_rst | ~synced[0];

   // decode the standby field of register b
   function automatic speed_standby_pkg::standby_t stby_decode
      (input logic [1:0] code);
      if (code == speed_standby_pkg::STBY_CODE_STOP)
         stby_decode = speed_standby_pkg::stby_stop;
      else if (code == speed_standby_pkg::STBY_CODE_PAUSE)
         stby_decode = speed_standby_pkg::stby_pause;
      else
         stby_decode = speed_standby_pkg::stby_run;
   endfunction : stby_decode

   wire b_top = reg_b[speed_standby_pkg::SPEED_BIT]; // double request
   wire e_top = reg_e[speed_standby_pkg::SPEED_BIT]; // quad request
   wire both_top = b_top & e_top;
   // faster rates only in voltage mode, reserved falls back to 1x
   wire [2:0] next_factor = (!voltage_mode || both_top) ?
      speed_standby_pkg::FACTOR_1X :
      b_top ? speed_standby_pkg::FACTOR_2X :
      e_top ? speed_standby_pkg::FACTOR_4X :
      speed_standby_pkg::FACTOR_1X;
   wire ltd = reg_e[speed_standby_pkg::LTD_BIT];
   speed_standby_pkg::standby_t standby; // current standby state
   wire speed_standby_pkg::standby_t next_standby =
      stby_decode(reg_b[speed_standby_pkg::STBY_LSB +: 2]);
   wire stopping = (standby == speed_standby_pkg::stby_stop);
   wire pausing = (standby == speed_standby_pkg::stby_pause);
   wire in_standby = stopping | pausing;

   // mode registers
   always_ff @(posedge clk_sys)
   begin
      dev_rst <= next_dev_rst;
      if (dev_rst)
      begin
         standby <= speed_standby_pkg::stby_run;
         overspeed_factor <= speed_standby_pkg::FACTOR_1X;
         speed_reserved <= 1'b0;
         fifo_bypass <= 1'b0;
      end
      else
      begin
         standby <= next_standby;
         overspeed_factor <= next_factor;
         speed_reserved <= both_top;
         fifo_bypass <= ltd;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // disc speed window for lock-to-disc
   ////////////////////////////////////////////////////////////////////
   localparam logic [15:0] NOM = NOMINAL_INTERVAL[15:0];
   localparam int SLOW_I = NOMINAL_INTERVAL *
      speed_standby_pkg::LOCK_SLOW_DIV;
   localparam logic [15:0] SLOW = SLOW_I[15:0];
   logic tick_d; // previous synced tick level
   logic [15:0] interval; // cycles since the last tick
   wire tick_rise = synced[2] & ~tick_d; // rotation tick edge
   wire too_slow = (interval > SLOW); // below quarter speed
   wire too_fast = tick_rise & (interval < NOM); // above nominal
   // restart at one so the count at the next rise equals the tick spacing
   wire [15:0] next_interval = tick_rise ? 16'h0001 :
      too_slow ? interval : interval + 16'h0001;

   // measure the tick interval and judge the range
   always_ff @(posedge clk_sys)
   begin
      if (dev_rst)
      begin
         tick_d <= 1'b0;
         interval <= 16'h0000;
         lock_in_range <= 1'b0;
      end
      else
      begin
         tick_d <= synced[2];
         interval <= next_interval;
         if (too_slow || too_fast)
            lock_in_range <= 1'b0;
         else if (tick_rise)
            lock_in_range <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // standby pin gating
   ////////////////////////////////////////////////////////////////////
   wire next_sclk = ltd ? sclk_disc : sclk_xtal;
   wire next_wclk = ltd ? wclk_disc : wclk_xtal;
   wire [1:0] motor_src = motor_pdm_mode ? motor_pdm : motor_pwm;
   wire next_motor_oe_n = dev_rst | stopping;

   // output flip-flops for the gated pins
   always_ff @(posedge clk_sys)
   begin
      audio_sclk_out <= next_sclk;
      audio_wclk_out <= next_wclk;
      audio_data_out <= audio_data;
      c2_error_flag_out <= c2_error;
      biphase_mark_out <= biphase_data;
      motor_drive_out_a <= motor_src[0];
      motor_drive_out_b <= motor_src[1];
      motor_oe_n <= next_motor_oe_n;
      if (dev_rst)
      begin
         audio_oe_n <= 1'b0;
         core_active <= 1'b0;
         subcode_enable <= 1'b0;
      end
      else
      begin
         audio_oe_n <= in_standby;
         core_active <= 1'b1;
         subcode_enable <= ~stopping;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pins that ignore standby
   ////////////////////////////////////////////////////////////////////
   wire [7:0] host_half = host_clk_12m_sel ?
      speed_standby_pkg::HOST_HI_HALF : speed_standby_pkg::HOST_LO_HALF;

   // fixed auxiliary clock, runs from system reset only
   clock_divider u_aux_div
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .half_count(speed_standby_pkg::AUX_HALF),
      .clk_out(fixed_aux_clock_out)
   );

   // host clock at 4 or 12 MHz
   clock_divider u_host_div
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .half_count(host_half),
      .clk_out(selectable_host_clock_out)
   );

   // pass-through flops, no standby term anywhere
   always_ff @(posedge clk_sys)
   begin
      crystal_out <= ~synced[1];
      sda_out <= 1'b0;
      sda_oe_n <= ~sda_drive_low;
      versatile_in_sync <= synced[4:3];
      versatile_out <= versatile_drive;
      correction_flag_out <= 1'b0;
      correction_flag_oe_n <= correction_flag;
      device_in_reset <= dev_rst;
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst || dev_rst);

   stop_motor_hiz_a: assert property (
      stopping |=> motor_oe_n)
      else $error("motor pins driven in stop standby");
   pause_motor_run_a: assert property (
      pausing && !next_dev_rst |=> !motor_oe_n && subcode_enable)
      else $error("motor or subcode off in hot pause");
   audio_hiz_a: assert property (
      in_standby |=> audio_oe_n)
      else $error("audio pins driven in standby");
   quad_speed_a: assert property (
      voltage_mode && e_top && !b_top && !next_dev_rst
      |=> overspeed_factor == speed_standby_pkg::FACTOR_4X)
      else $error("quad speed not selected");
   current_only_a: assert property (
      !voltage_mode |=> overspeed_factor == speed_standby_pkg::FACTOR_1X)
      else $error("fast rate outside voltage mode");
   fifo_bypass_a: assert property (
      ltd && !next_dev_rst |=> fifo_bypass && audio_sclk_out == $past(sclk_disc))
      else $error("lock-to-disc not followed");
   host_sda_a: assert property (
      sda_drive_low |=> !sda_oe_n)
      else $error("host data line blocked");
   core_run_a: assert property (
      in_standby && !next_dev_rst |=> core_active [*2])
      else $error("core stopped in standby");
   aux_clock_a: assert property (
      fixed_aux_clock_out |-> ##[1:8] !fixed_aux_clock_out)
      else $error("auxiliary clock stuck");
endmodule : speed_standby_ctrl

/* mode_host_model.sv */
// host-side model: decoder register images and the disc rotation tick pin
// assumes put_regs is called just after a rising edge of clk_sys
`timescale 1ns/10ps
module mode_host_model
(
   // clock
   input wire logic clk_sys,
   // disc tick spacing in cycles, zero stops the disc
   input wire logic [15:0] tick_gap,
   // register images and tick pin
   output logic [3:0] reg_b,
   output logic [3:0] reg_e,
   output logic disc_tick
);
   logic [15:0] tick_cnt; // cycles since the last tick
   logic tick_due; // spacing reached this cycle

   assign tick_due = (tick_cnt + 16'h1 >= tick_gap);

   ////////////////////////////////////////////////////////////
   // idle images at time zero, tick line low while the disc stands
   initial
   begin
      reg_b = 4'h0;
      reg_e = 4'h0;
      disc_tick = 1'b0;
      tick_cnt = 16'h0;
   end

   // both images change at one edge; both top bits only when a test asks
   task automatic put_regs(input logic [3:0] b, input logic [3:0] e);
      reg_b <= b;
      reg_e <= e;
   endtask : put_regs

   // one-cycle tick per rotation, spacing set by tick_gap
   always @(posedge clk_sys)
   begin
      tick_cnt <= tick_due ? 16'h0 : tick_cnt + 16'h1;
      disc_tick <= (tick_gap != 16'h0) && tick_due;
   end
endmodule : mode_host_model

/* decoder_speed_standby_control_bench.sv */
// self-checking bench for the speed, lock-to-disc and standby control
// assumes the host model file is compiled before this one
`timescale 1ns/10ps
module decoder_speed_standby_control_bench;
   localparam int NOM = 20; // short disc interval keeps the run brief
   // stimulus
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic reset_n = 1'b1;
   logic voltage_mode = 1'b1;
   logic host_clk_12m_sel = 1'b0;
   logic motor_pdm_mode = 1'b0;
   logic crystal_in = 1'b0;
   logic sda_in = 1'b1;
   logic sda_drive_low = 1'b0;
   logic correction_flag = 1'b0;
   logic [1:0] vpin = 2'h0; // {second, first}
   logic [6:0] src = 7'h00; // xtal clocks, disc clocks, data, c2, biphase
   logic [1:0] motor_pwm = 2'h0;
   logic [1:0] motor_pdm = 2'h0;
   logic [2:0] versatile_drive = 3'h0;
   logic [15:0] tick_gap = 16'h0;
   // observed
   wire [3:0] reg_b, reg_e;
   wire disc_tick, speed_reserved, fifo_bypass, lock_in_range, core_active;
   wire subcode_enable, device_in_reset, audio_oe_n, motor_oe_n, crystal_out;
   wire fixed_aux_clock_out, selectable_host_clock_out, sda_oe_n;
   wire correction_flag_oe_n;
   wire [2:0] overspeed_factor, versatile_out;
   wire [4:0] aout; // sclk, wclk, data, c2 flag, biphase
   wire [1:0] mout; // {b, a}
   wire [1:0] versatile_in_sync;
   wire [1:0] od_low; // {sda_out, correction_flag_out}
   int errors = 0;
   int checks = 0;
   int aux_n = 0;
   int host_n = 0;
   logic aux_q = 1'b0;
   logic host_q = 1'b0;

   always #4 clk_sys = ~clk_sys;

   mode_host_model u_host (.clk_sys, .tick_gap, .reg_b, .reg_e, .disc_tick);

   speed_standby_ctrl #(.NOMINAL_INTERVAL(NOM)) u_dut (.clk_sys, .sys_rst, .reset_n,
      .reg_b, .reg_e, .voltage_mode, .host_clk_12m_sel, .motor_pdm_mode, .crystal_in,
      .disc_tick, .versatile_pin_first(vpin[0]), .versatile_pin_second(vpin[1]), .sda_in,
      .sclk_xtal(src[6]), .wclk_xtal(src[5]), .sclk_disc(src[4]), .wclk_disc(src[3]),
      .audio_data(src[2]), .c2_error(src[1]), .biphase_data(src[0]), .motor_pwm,
      .motor_pdm, .sda_drive_low, .correction_flag, .versatile_drive, .overspeed_factor,
      .speed_reserved, .fifo_bypass, .lock_in_range, .core_active, .subcode_enable,
      .device_in_reset, .audio_sclk_out(aout[4]), .audio_wclk_out(aout[3]),
      .audio_data_out(aout[2]), .c2_error_flag_out(aout[1]), .biphase_mark_out(aout[0]),
      .audio_oe_n, .motor_drive_out_a(mout[0]), .motor_drive_out_b(mout[1]), .motor_oe_n,
      .crystal_out, .fixed_aux_clock_out, .selectable_host_clock_out, .sda_out(od_low[1]),
      .sda_oe_n, .versatile_in_sync, .versatile_out, .correction_flag_out(od_low[0]),
      .correction_flag_oe_n);

   ////////////////////////////////////////////////////////////
   // rising edges of the two divided clocks
   always @(posedge clk_sys)
   begin
      aux_q <= fixed_aux_clock_out;
      host_q <= selectable_host_clock_out;
      if (fixed_aux_clock_out && !aux_q)
         aux_n++;
      if (selectable_host_clock_out && !host_q)
         host_n++;
   end

   // compare one value, count it, report a difference
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // counts and verdict, then stop
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   // bounded wait for the disc window flag
   task automatic wait_lock(input logic want);
      int n;
      for (n = 0; n < 400 && lock_in_range !== want; n++)
         @(posedge clk_sys);
      if (n == 400)
      begin
         errors++;
         give_verdict();
      end
      check(lock_in_range, want, "disc range");
   endtask : wait_lock

   // edges of both clocks over 120 cycles, one edge of slack
   task automatic count_clocks(input int half_host);
      int a0;
      int h0;
      a0 = aux_n;
      h0 = host_n;
      repeat (120) @(posedge clk_sys);
      a0 = aux_n - a0 - 120 / (2 * speed_standby_pkg::AUX_HALF_I);
      h0 = host_n - h0 - 120 / (2 * half_host);
      check(a0 >= -1 && a0 <= 1, 1'b1, "aux clock");
      check(h0 >= -1 && h0 <= 1, 1'b1, "host clock");
   endtask : count_clocks

   ////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      logic [2:0] exp;
      logic [15:0] gaps [6];
      // in range, fast, slowest edge, fast, nominal edge, stopped
      gaps = '{16'h0028, 16'h000A, 16'h0050, 16'h000A, 16'h0014, 16'h0000};
      repeat (5) @(posedge clk_sys);
      check({motor_oe_n, device_in_reset}, 2'h3, "in reset");
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check({core_active, subcode_enable, audio_oe_n, motor_oe_n}, 4'hC, "run");
      $display("test reset done");
      // every speed code against every supply mode
      for (int i = 0; i < 8; i++)
      begin
         voltage_mode <= i[2];
         u_host.put_regs({i[1], 3'h0}, {i[0], 3'h0});
         repeat (3) @(posedge clk_sys);
         exp = (!i[2] || i[1] == i[0]) ? speed_standby_pkg::FACTOR_1X :
            (i[1] ? speed_standby_pkg::FACTOR_2X : speed_standby_pkg::FACTOR_4X);
         check(overspeed_factor, exp, "speed");
         check(speed_reserved, i[1] & i[0], "reserved");
      end
      $display("test speed done");
      // lock-to-disc switches the audio source and the window
      src <= 7'h1D;
      u_host.put_regs(4'h0, 4'h1);
      repeat (3) @(posedge clk_sys);
      check({fifo_bypass, aout}, 6'h3D, "lock on");
      for (int g = 0; g < 6; g++)
      begin
         tick_gap <= gaps[g];
         wait_lock(g % 2 == 0);
      end
      u_host.put_regs(4'h0, 4'h0);
      repeat (3) @(posedge clk_sys);
      check({fifo_bypass, aout}, 6'h05, "lock off");
      $display("test lock done");
      // stop standby with every other pin group busy
      u_host.put_regs(4'h1, 4'h0);
      {motor_pwm, correction_flag, versatile_drive, sda_drive_low, vpin} <= 9'h1EE;
      crystal_in <= 1'b1;
      repeat (6) @(posedge clk_sys);
      check({audio_oe_n, motor_oe_n, subcode_enable, core_active}, 4'hD, "stop");
      check(sda_oe_n, 1'b0, "host line");
      check(od_low, 2'h0, "open drain");
      check({correction_flag_oe_n, versatile_out, versatile_in_sync}, 6'h36, "pins");
      check(crystal_out, 1'b0, "crystal");
      count_clocks(speed_standby_pkg::HOST_LO_HALF_I);
      host_clk_12m_sel <= 1'b1;
      repeat (40) @(posedge clk_sys);
      count_clocks(speed_standby_pkg::HOST_HI_HALF_I);
      $display("test stop done");
      // hot pause keeps the motor pins in both drive modes
      u_host.put_regs(4'h2, 4'h0);
      {motor_pdm_mode, motor_pdm, motor_pwm} <= 5'h19;
      repeat (6) @(posedge clk_sys);
      check({audio_oe_n, motor_oe_n, subcode_enable, mout}, 5'h16, "pause pdm");
      motor_pdm_mode <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(mout, 2'h1, "pause pwm");
      // reset pin, then normal audio again
      reset_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      check({motor_oe_n, device_in_reset, core_active}, 3'h6, "pin reset");
      reset_n <= 1'b1;
      u_host.put_regs(4'h0, 4'h0);
      repeat (8) @(posedge clk_sys);
      check({audio_oe_n, motor_oe_n, core_active}, 3'h1, "resume");
      $display("test pause done");
      give_verdict();
   end
endmodule : decoder_speed_standby_control_bench
